// [rtl/sonet_section_line_overhead.sv]
// Section and line overhead: error counts, alarm detection, transmit overhead control
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`include "sloh_cfg.svh"

module sonet_section_line_overhead import sloh_pkg::*; #(
    parameter int B2_ERR_WIDTH = 7
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic RX_FRAME,
    input wire logic [3:0] RX_B1_ERRS,
    input wire logic [7:0] RX_K2,
    input wire logic [B2_ERR_WIDTH-1:0] RX_B2_ERRS,
    input wire logic [4:0] RX_FAR_ERRS,
    input wire logic [7:0] RX_DATA,
    output logic [7:0] DOWN_DATA,
    output logic [B2_ERR_WIDTH-1:0] B2_TO_TX,
    output logic B2_TO_TX_VALID,
    output logic [19:0] LINE_PARITY_COUNT,
    output logic [19:0] LINE_FAR_COUNT,
    input wire logic TX_FRAME,
    input wire logic TX_OVERHEAD,
    input wire logic TX_A1,
    input wire logic TX_B1,
    input wire logic TX_NO_SCRAMBLE,
    input wire logic [7:0] TX_DATA_IN,
    output logic [7:0] TX_DATA_OUT,
    output logic IRQ
);

    initial begin
        if (B2_ERR_WIDTH != 7) begin
            $error("B2_ERR_WIDTH must be 7 to hold up to 96 errors per frame");
        end
        if (`POLL_LATENCY > `POLL_CYCLES) begin
            $error("Counter poll latency exceeds the allowed transfer time");
        end
    end

    state_type r;
    state_type next_r;

    // Byte-wide frame-synchronous scrambler, x^7 + x^6 + 1, first bit in MSB
    function automatic logic [14:0] scramble_step(input logic [6:0] s);
        logic [6:0] st;
        logic [7:0] key;
        st = s;
        key = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            key[i] = st[6];
            st = {st[5:0], st[6] ^ st[5]};
        end
        return {st, key};
    endfunction

    // Run length of frames disagreeing with the declared state
    function automatic logic [3:0] defect_step(input logic state, input logic match,
                                               input logic [2:0] run, input logic fast);
        logic [2:0] limit;
        logic [2:0] nrun;
        limit = fast ? `FRAMES_FAST : `FRAMES_SLOW;
        nrun = (match != state) ? 3'(run + 3'h1) : 3'h0;
        if (nrun >= limit) begin
            return {~state, 3'h0};
        end
        return {state, nrun};
    endfunction

    logic [16:0] sect_sum;
    logic [20:0] b2_sum;
    logic [20:0] far_sum;
    logic [6:0] b2_add;
    logic [4:0] far_add;
    logic [3:0] alarm_res;
    logic [3:0] remote_res;
    logic [14:0] scr_res;
    logic [7:0] tx_byte;
    logic [7:0] tx_scr;
    logic [6:0] scr_now;
    logic [7:0] bip_now;
    logic sect_poll;
    logic global_poll;
    logic tx_alarm;

    always_comb begin
        next_r = r;
        next_r.rdata = 8'h00;
        global_poll = WR && (ADDR == `OFF_MASTER_RESET);
        sect_poll = global_poll ||
                    (WR && (ADDR == `OFF_SPC_LOW || ADDR == `OFF_SPC_HIGH));

        // Register writes
        if (WR) begin
            if (ADDR == `OFF_RX_SECT_CTRL) begin
                next_r.sect_int_en = WDATA[`BIT_SECT_PAR_INT_EN];
            end else if (ADDR == `OFF_TX_SECT_CTRL) begin
                next_r.tx_ctrl = WDATA[6:0];
            end else if (ADDR == `OFF_TX_SECT_DIAG) begin
                next_r.tx_diag = WDATA[2:0];
            end else if (ADDR == `OFF_RX_LINE_CTRL) begin
                next_r.line_ctrl = WDATA[7:2];
            end else if (ADDR == `OFF_RX_LINE_INT) begin
                next_r.line_int_en = WDATA[7:4];
            end
        end

        // Register reads; clear-on-read of the flag registers
        if (RD) begin
            if (ADDR == `OFF_RX_SECT_CTRL) begin
                next_r.rdata = {4'h0, r.sect_int_en, 3'h0};
            end else if (ADDR == `OFF_RX_SECT_STAT) begin
                next_r.rdata = {1'b0, r.sect_par_flag, 6'h00};
                next_r.sect_par_flag = 1'b0;
            end else if (ADDR == `OFF_SPC_LOW) begin
                next_r.rdata = r.section_parity_count[7:0];
            end else if (ADDR == `OFF_SPC_HIGH) begin
                next_r.rdata = r.section_parity_count[15:8];
            end else if (ADDR == `OFF_TX_SECT_CTRL) begin
                next_r.rdata = {1'b0, r.tx_ctrl};
            end else if (ADDR == `OFF_TX_SECT_DIAG) begin
                next_r.rdata = {5'h00, r.tx_diag};
            end else if (ADDR == `OFF_RX_LINE_CTRL) begin
                next_r.rdata = {r.line_ctrl, r.line_alarm_state,
                                r.line_remote_defect_state};
            end else if (ADDR == `OFF_RX_LINE_INT) begin
                next_r.rdata = {r.line_int_en, r.line_int_flag};
                next_r.line_int_flag = 4'h0;
            end
        end

        // Section parity accumulation; errors of the poll cycle seed the new count
        sect_sum = {1'b0, r.sect_acc} + {13'h0000, RX_B1_ERRS};
        if (RX_FRAME && RX_B1_ERRS != 4'h0) begin
            next_r.sect_par_flag = 1'b1;
        end
        if (sect_poll) begin
            next_r.section_parity_count = r.sect_acc;
            next_r.sect_acc = RX_FRAME ? {12'h000, RX_B1_ERRS} : 16'h0000;
        end else if (RX_FRAME) begin
            next_r.sect_acc = sect_sum[16] ? 16'hFFFF : sect_sum[15:0];
        end

        // Line B2 and far-end error accumulation
        b2_add = r.line_ctrl[`BIT_PARITY_WORD - 2] ?
                 {6'h00, RX_B2_ERRS != 7'h00} : RX_B2_ERRS;
        if (RX_FAR_ERRS > `FAR_MAX_VALUE) begin
            far_add = 5'h00;
        end else if (r.line_ctrl[`BIT_FAR_WORD - 2] && RX_FAR_ERRS > `FAR_WORD_CAP) begin
            far_add = `FAR_WORD_CAP;
        end else begin
            far_add = RX_FAR_ERRS;
        end
        b2_sum = {1'b0, r.b2_acc} + {14'h0000, b2_add};
        far_sum = {1'b0, r.far_acc} + {16'h0000, far_add};
        if (global_poll) begin
            next_r.b2_count = r.b2_acc;
            next_r.far_count = r.far_acc;
            next_r.b2_acc = RX_FRAME ? {13'h0000, b2_add} : 20'h00000;
            next_r.far_acc = RX_FRAME ? {15'h0000, far_add} : 20'h00000;
        end else if (RX_FRAME) begin
            next_r.b2_acc = b2_sum[20] ? 20'hFFFFF : b2_sum[19:0];
            next_r.far_acc = far_sum[20] ? 20'hFFFFF : far_sum[19:0];
        end

        // Outbound B2 indication to the transmit line side
        next_r.b2_out_valid = RX_FRAME;
        if (RX_FRAME) begin
            next_r.b2_out = r.line_ctrl[`BIT_OUT_WORD - 2] ?
                            {6'h00, RX_B2_ERRS != 7'h00} : RX_B2_ERRS;
        end

        // K2 defect detection, once per received frame
        alarm_res = defect_step(r.line_alarm_state, RX_K2[2:0] == `K2_ALARM_PATTERN,
                                r.alarm_run, r.line_ctrl[`BIT_FAST_ALARM - 2]);
        remote_res = defect_step(r.line_remote_defect_state,
                                 RX_K2[2:0] == `K2_REMOTE_PATTERN,
                                 r.remote_run, r.line_ctrl[`BIT_FAST_REMOTE - 2]);
        if (RX_FRAME) begin
            next_r.line_alarm_state = alarm_res[3];
            next_r.alarm_run = alarm_res[2:0];
            next_r.line_remote_defect_state = remote_res[3];
            next_r.remote_run = remote_res[2:0];
            if (alarm_res[3] != r.line_alarm_state) begin
                next_r.line_int_flag[`BIT_ALARM_INT_FLAG] = 1'b1;
            end
            if (remote_res[3] != r.line_remote_defect_state) begin
                next_r.line_int_flag[`BIT_REMOTE_INT_FLAG] = 1'b1;
            end
            if (RX_B2_ERRS != 7'h00) begin
                next_r.line_int_flag[`BIT_PAR_INT_FLAG] = 1'b1;
            end
            if (RX_FAR_ERRS != 5'h00) begin
                next_r.line_int_flag[`BIT_FAR_INT_FLAG] = 1'b1;
            end
        end

        // Downstream data forced to ones while declared alarm is present
        if (r.line_ctrl[`BIT_AUTO_ONES - 2] && next_r.line_alarm_state) begin
            next_r.down_data = 8'hFF;
        end else begin
            next_r.down_data = RX_DATA;
        end

        // Transmit path: alarm insertion changes only at a frame start
        tx_alarm = r.alarm_active;
        if (TX_FRAME) begin
            tx_alarm = r.tx_ctrl[`BIT_TX_ALARM_INSERT];
        end
        next_r.alarm_active = tx_alarm;
        tx_byte = TX_DATA_IN;
        if (tx_alarm && !TX_OVERHEAD) begin
            tx_byte = 8'hFF;
        end
        if (TX_A1) begin
            tx_byte = r.tx_diag[`BIT_FRAMING_INJECT] ? `A1_CORRUPT : `A1_NORMAL;
        end
        if (TX_B1) begin
            tx_byte = r.tx_diag[`BIT_PARITY_CORRUPT] ? ~r.b1_hold : r.b1_hold;
        end

        scr_now = TX_FRAME ? `SCRAMBLE_SEED : r.scr;
        scr_res = scramble_step(scr_now);
        next_r.scr = TX_NO_SCRAMBLE ? scr_now : scr_res[14:8];
        if (r.tx_ctrl[`BIT_SCRAMBLE_DISABLE] || TX_NO_SCRAMBLE) begin
            tx_scr = tx_byte;
        end else begin
            tx_scr = tx_byte ^ scr_res[7:0];
        end

        // Parity over the sent frame, inserted as B1 of the next
        bip_now = TX_FRAME ? 8'h00 : r.bip;
        next_r.bip = bip_now ^ tx_scr;
        if (TX_FRAME) begin
            next_r.b1_hold = r.bip;
        end
        next_r.tx_data = r.tx_diag[`BIT_FORCE_ZERO] ? 8'h00 : tx_scr;

        next_r.irq = (next_r.sect_par_flag && next_r.sect_int_en) ||
                     ((next_r.line_int_flag & next_r.line_int_en) != 4'h0);
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            r <= '0;
            r.tx_ctrl <= 7'(`RESET_CTRL);
            r.scr <= `SCRAMBLE_SEED;
        end else begin
            r <= next_r;
        end
    end

    assign RDATA = r.rdata;
    assign DOWN_DATA = r.down_data;
    assign B2_TO_TX = r.b2_out;
    assign B2_TO_TX_VALID = r.b2_out_valid;
    assign LINE_PARITY_COUNT = r.b2_count;
    assign LINE_FAR_COUNT = r.far_count;
    assign TX_DATA_OUT = r.tx_data;
    assign IRQ = r.irq;

endmodule

// [rtl/sloh_cfg.svh]
// Offsets, field positions, reset values and timing counts of the overhead block
`ifndef SLOH_CFG_SVH
`define SLOH_CFG_SVH

`define OFF_MASTER_RESET 8'h00
`define OFF_RX_SECT_CTRL 8'h10
`define OFF_RX_SECT_STAT 8'h11
`define OFF_SPC_LOW 8'h12
`define OFF_SPC_HIGH 8'h13
`define OFF_TX_SECT_CTRL 8'h14
`define OFF_TX_SECT_DIAG 8'h15
`define OFF_RX_LINE_CTRL 8'h18
`define OFF_RX_LINE_INT 8'h19

`define BIT_SECT_PAR_INT_EN 3
`define BIT_SECT_PAR_INT_FLAG 6
`define BIT_TX_ALARM_INSERT 0
`define BIT_SCRAMBLE_DISABLE 6
`define BIT_FRAMING_INJECT 0
`define BIT_PARITY_CORRUPT 1
`define BIT_FORCE_ZERO 2
`define BIT_PARITY_WORD 7
`define BIT_AUTO_ONES 6
`define BIT_FAST_ALARM 5
`define BIT_FAST_REMOTE 4
`define BIT_OUT_WORD 3
`define BIT_FAR_WORD 2
`define BIT_ALARM_STATE 1
`define BIT_REMOTE_STATE 0
`define BIT_FAR_INT_EN 7
`define BIT_PAR_INT_EN 6
`define BIT_ALARM_INT_EN 5
`define BIT_REMOTE_INT_EN 4
`define BIT_FAR_INT_FLAG 3
`define BIT_PAR_INT_FLAG 2
`define BIT_ALARM_INT_FLAG 1
`define BIT_REMOTE_INT_FLAG 0

`define RESET_CTRL 8'h00
`define A1_NORMAL 8'hF6
`define A1_CORRUPT 8'h76
`define K2_REMOTE_PATTERN 3'b110
`define K2_ALARM_PATTERN 3'b111
`define FRAMES_FAST 3'h3
`define FRAMES_SLOW 3'h5
`define FAR_WORD_CAP 5'h04
`define FAR_MAX_VALUE 5'h18
`define SCRAMBLE_SEED 7'h7F

`define CLOCK_PERIOD_NS 50
`define POLL_TIME_NS 7000
`define POLL_CYCLES (`POLL_TIME_NS / `CLOCK_PERIOD_NS)
`define POLL_LATENCY 1

`endif

// [rtl/sloh_pkg.sv]
// Types shared by the overhead block
package sloh_pkg;

    typedef struct packed {
        logic [7:0] rdata;
        logic sect_int_en;
        logic sect_par_flag;
        logic [15:0] sect_acc;
        logic [15:0] section_parity_count;
        logic [6:0] tx_ctrl;
        logic [2:0] tx_diag;
        logic [5:0] line_ctrl;
        logic [3:0] line_int_en;
        logic [3:0] line_int_flag;
        logic line_alarm_state;
        logic line_remote_defect_state;
        logic [2:0] alarm_run;
        logic [2:0] remote_run;
        logic [19:0] b2_acc;
        logic [19:0] far_acc;
        logic [19:0] b2_count;
        logic [19:0] far_count;
        logic [6:0] b2_out;
        logic b2_out_valid;
        logic [7:0] down_data;
        logic alarm_active;
        logic [6:0] scr;
        logic [7:0] bip;
        logic [7:0] b1_hold;
        logic [7:0] tx_data;
        logic irq;
    } state_type;

endpackage

// [dv/sonet_section_line_overhead_chk.sv]
// Port-level checks for the overhead block
`timescale 1ns/100ps
module sonet_section_line_overhead_chk (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic [7:0] ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic RX_FRAME,
    input wire logic [7:0] RX_DATA,
    input wire logic [7:0] DOWN_DATA,
    input wire logic B2_TO_TX_VALID,
    input wire logic [19:0] LINE_PARITY_COUNT,
    input wire logic TX_A1,
    input wire logic [7:0] TX_DATA_OUT,
    input wire logic IRQ
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    property p_rd_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_flag_reg; $past(RD && ADDR == 8'h11) |-> (RDATA & 8'hBF) == 8'h00; endproperty
    a_flag_reg: assert property (p_flag_reg) else $error("stray status bits");
    property p_b2_valid; !$past(SYS_RST) |-> B2_TO_TX_VALID == $past(RX_FRAME); endproperty
    a_b2_valid: assert property (p_b2_valid) else $error("b2 strobe misplaced");
    property p_irq_rise; $rose(IRQ) |-> $past(RX_FRAME || WR) || $past(WR, 2); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose with no cause");
    property p_irq_fall; $fell(IRQ) |-> $past(RD || WR) || $past(RD || WR, 2); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell with no access");
    property p_poll; !$stable(LINE_PARITY_COUNT) |-> $past(WR && ADDR == 8'h00); endproperty
    a_poll: assert property (p_poll) else $error("count moved without poll");
    property p_down;
        !$past(SYS_RST) && DOWN_DATA != 8'hFF |-> DOWN_DATA == $past(RX_DATA);
    endproperty
    a_down: assert property (p_down) else $error("downstream byte wrong");
    property p_a1;
        !$past(SYS_RST) && $past(TX_A1) |-> TX_DATA_OUT inside {8'hF6, 8'h76, 8'h00};
    endproperty
    a_a1: assert property (p_a1) else $error("framing byte wrong");
    c_irq: cover property ($rose(IRQ));
    c_ones: cover property (DOWN_DATA == 8'hFF);
    c_poll: cover property ($past(WR && ADDR == 8'h00));
endmodule

bind sonet_section_line_overhead sonet_section_line_overhead_chk i_chk (.CLOCK(CLOCK),
    .SYS_RST(SYS_RST), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .RX_FRAME(RX_FRAME),
    .RX_DATA(RX_DATA), .DOWN_DATA(DOWN_DATA), .B2_TO_TX_VALID(B2_TO_TX_VALID),
    .LINE_PARITY_COUNT(LINE_PARITY_COUNT), .TX_A1(TX_A1), .TX_DATA_OUT(TX_DATA_OUT), .IRQ(IRQ));

// [dv/sloh_far_end.sv]
// Far-end line model: frame strobe every eight bytes, payload repeats every 256 bytes
`timescale 1ns/100ps
module sloh_far_end (
    input wire logic clock,
    output logic frame,
    output logic [7:0] data
);
    logic [2:0] cnt = 3'h0;
    initial frame = 1'b0;
    initial data = 8'h5A;
    always @(posedge clock) begin
        cnt <= cnt + 3'h1;
        frame <= cnt == 3'h0;
        data <= data + 8'h3B;
    end
endmodule

// [dv/sonet_section_line_overhead_tb.sv]
// Self-checking bench for the overhead block
`timescale 1ns/100ps
module sonet_section_line_overhead_tb;
    logic clock = 1'b0, sys_rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, rd_d, tx_v = 1'b0, tv_d;
    logic rx_frame, b2_v, irq;
    logic [7:0] addr = 8'h00, wdata = 8'h00, k2 = 8'h00, tx_in = 8'h00;
    logic [7:0] rdata, rx_data, down, tx_out;
    logic [3:0] b1 = 4'h0;
    logic [6:0] b2 = 7'h00, b2_tx, eo;
    logic [4:0] far = 5'h00, tk = 5'h00;
    logic [19:0] par_cnt, far_cnt, ep, ef;
    logic [7:0] rq[$], tq[$], regs[6] = '{8'h10, 8'h14, 8'h15, 8'h18, 8'h19, 8'h30};
    logic [7:0] pat[2] = '{8'h07, 8'h06}, ctl[2] = '{8'h60, 8'h00}, st[2] = '{8'h02, 8'h01};
    int fails = 0, compares = 0, seed = 32'h9E45, sum, i, m, k;
    always #25 clock = ~clock;
    sloh_far_end i_sloh_far_end (.clock(clock), .frame(rx_frame), .data(rx_data));
    sonet_section_line_overhead i_sonet_section_line_overhead (.CLOCK(clock), .SYS_RST(sys_rst),
        .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .RX_FRAME(rx_frame),
        .RX_B1_ERRS(b1), .RX_K2(k2), .RX_B2_ERRS(b2), .RX_FAR_ERRS(far), .RX_DATA(rx_data),
        .DOWN_DATA(down), .B2_TO_TX(b2_tx), .B2_TO_TX_VALID(b2_v), .LINE_PARITY_COUNT(par_cnt),
        .LINE_FAR_COUNT(far_cnt), .TX_FRAME(tk[4]), .TX_OVERHEAD(tk[3]), .TX_A1(tk[2]),
        .TX_B1(tk[1]), .TX_NO_SCRAMBLE(tk[0]), .TX_DATA_IN(tx_in), .TX_DATA_OUT(tx_out), .IRQ(irq));
    task chk(input string n, input logic [19:0] e, g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task finish_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock);
        wr_s <= 1'b0;
    endtask
    task rd(input logic [7:0] a, e);
        @(posedge clock);
        addr <= a;
        rd_s <= 1'b1;
        rq.push_back(e);
        @(posedge clock);
        rd_s <= 1'b0;
    endtask
    task tx(input logic [4:0] c, input logic [7:0] d, e);
        @(posedge clock);
        tk <= c;
        tx_in <= d;
        tx_v <= 1'b1;
        tq.push_back(e);
    endtask
    task tx_end;
        @(posedge clock);
        tk <= 5'h00;
        tx_v <= 1'b0;
    endtask
    task frames(input int n);
        repeat (n) begin
            k = 0;
            do @(posedge clock); while (!rx_frame && ++k < 20);
            if (k == 20) begin
                fails++;
                finish_test;
            end
        end
    endtask
    // Results land one cycle after the request is sampled
    always @(posedge clock) begin
        rd_d <= rd_s;
        tv_d <= tx_v;
        if (rd_d)
            chk("rdata", rq.pop_front(), rdata);
        if (tv_d)
            chk("tx_out", tq.pop_front(), tx_out);
    end
    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        foreach (regs[j])
            rd(regs[j], 8'h00);
        wr(8'h18, 8'hFF);
        rd(8'h18, 8'hFC);
        wr(8'h14, 8'h40);
        rd(8'h14, 8'h40);
        $display("end registers");
        wr(8'h10, 8'h08);
        wr(8'h12, 8'h00);
        for (m = 0; m < 2; m++) begin
            sum = 0;
            b1 <= 4'h8;
            for (i = 0; i < 3; i++) begin
                frames(1);
                sum += b1;
                b1 <= i < 2 ? 4'({$random(seed)} % 9) : 4'h0;
            end
            wr(8'h12 + 8'(m), 8'h00);
            rd(8'h12, sum[7:0]);
            rd(8'h13, sum[15:8]);
        end
        chk("irq", 20'h1, irq);
        rd(8'h11, 8'h40);
        rd(8'h11, 8'h00);
        wr(8'h10, 8'h00);
        $display("end section count");
        for (m = 0; m < 2; m++) begin
            wr(8'h18, ctl[m]);
            wr(8'h19, st[m] << 4);
            k2 <= pat[m];
            frames(m ? 4 : 2);
            rd(8'h18, ctl[m]);
            frames(1);
            k2 <= 8'h00;
            repeat (2) @(posedge clock);
            chk("irq", 20'h1, irq);
            rd(8'h18, ctl[m] | st[m]);
            if (m == 0)
                chk("down", 20'hFF, down);
            rd(8'h19, st[m] * 8'h11);
            frames(m ? 5 : 3);
            rd(8'h18, ctl[m]);
            rd(8'h19, st[m] * 8'h11);
            repeat (2) @(posedge clock);
            chk("irq", 20'h0, irq);
        end
        $display("end defects");
        for (m = 0; m < 2; m++) begin
            wr(8'h18, m ? 8'h8C : 8'h00);
            wr(8'h19, 8'hC0);
            wr(8'h00, 8'h00);
            ep = 20'h0;
            ef = 20'h0;
            b2 <= 7'h01;
            far <= 5'h06;
            for (i = 0; i < 3; i++) begin
                frames(1);
                ep += m ? 20'h1 : 20'(b2);
                ef += m && far > 5'h04 ? 20'h4 : 20'(far);
                eo = m ? 7'h01 : b2;
                b2 <= i < 2 ? 7'(1 + {$random(seed)} % 96) : 7'h00;
                far <= i < 2 ? 5'(1 + {$random(seed)} % 24) : 5'h00;
                @(posedge clock);
                chk("b2_tx", 20'(eo), 20'(b2_tx));
            end
            wr(8'h00, 8'h00);
            @(posedge clock);
            chk("par_cnt", ep, par_cnt);
            chk("far_cnt", ef, far_cnt);
            chk("irq", 20'h1, irq);
            rd(8'h19, 8'hCC);
        end
        $display("end line counts");
        for (m = 0; m < 2; m++) begin
            wr(8'h15, m ? 8'h03 : 8'h00);
            tx(5'h1D, 8'h00, m ? 8'h76 : 8'hF6);
            tx(5'h00, 8'h5A, 8'h5A);
            tx(5'h1D, 8'h00, m ? 8'h76 : 8'hF6);
            tx(5'h0A, 8'h00, m ? 8'hD3 : 8'hAC);
            tx_end;
        end
        wr(8'h15, 8'h04);
        tx(5'h00, 8'h5A, 8'h00);
        tx_end;
        wr(8'h15, 8'h00);
        wr(8'h14, 8'h41);
        tx(5'h00, 8'h5A, 8'h5A);
        tx(5'h1D, 8'h00, 8'hF6);
        tx(5'h00, 8'h5A, 8'hFF);
        tx(5'h08, 8'h33, 8'h33);
        tx_end;
        wr(8'h14, 8'h00);
        tx(5'h1D, 8'h00, 8'hF6);
        tx(5'h00, 8'h5A, 8'hA4);
        tx_end;
        repeat (4) @(posedge clock);
        $display("end transmit");
        finish_test;
    end
endmodule
